//--- core/bus_strobe_cfg.svh
// timing and fault constants for the bus strobe and wait state block
`ifndef BUS_STROBE_CFG_SVH
`define BUS_STROBE_CFG_SVH
`define TIMEOUT_EDGES 2
`define FAULT_WIDTH 16
`define FAULT_BIT_TIMEOUT 7
`define FAULT_RESET 16'h0000
`define LEVEL_MACHINE_ERROR 4'h1
`endif

//--- core/bus_strobe_pkg.sv
// types for the bus strobe and wait state block
package bus_strobe_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_STROBE = 3'b010,
		ST_LAST = 3'b011,
		ST_INTERNAL = 3'b100
	} cycle_state_t;
endpackage : bus_strobe_pkg

//--- core/timeout_detect.sv
// counts falling edges of the timeout clock while a strobe waits on ready
`timescale 1ns/1ns
`default_nettype none
`include "bus_strobe_cfg.svh"
module timeout_detect #(
	parameter int EDGES = `TIMEOUT_EDGES
) (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic timeout_clock_in,
	input wire logic waiting_in,
	input wire logic timeout_disable_n_in,
	output logic timeout_out
);
	logic timeout_clock_q;
	logic [3:0] count_q;
	logic fall;
	// ----------------------------------------
	// edge detection
	// ----------------------------------------
	// timeout clock is taken as synchronous, so one register finds its edge
	assign fall = timeout_clock_q & ~timeout_clock_in;
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			timeout_clock_q <= 1'b0;
		end else begin
			timeout_clock_q <= timeout_clock_in;
		end
	end
	always_ff @(posedge clk_in) begin
		if (reset_in || !waiting_in || !timeout_disable_n_in) begin
			count_q <= 4'h0;
		end else if (fall && count_q < 4'(EDGES)) begin
			count_q <= count_q + 4'h1;
		end
	end
	assign timeout_out = waiting_in && timeout_disable_n_in &&
		fall && (count_q == 4'(EDGES - 1));
	a_disable_blocks: assert property (@(posedge clk_in)
		disable iff (reset_in) !timeout_disable_n_in |-> !timeout_out)
		else $error("timeout raised while disabled");
	a_needs_waiting: assert property (@(posedge clk_in)
		disable iff (reset_in)
		timeout_out |-> waiting_in && $past(waiting_in))
		else $error("timeout without a waiting strobe");
endmodule : timeout_detect
`default_nettype wire

//--- core/bus_strobe_wait.sv
// machine cycle sequencer: strobes, wait states and bus timeout
`timescale 1ns/1ns
`default_nettype none
`include "bus_strobe_cfg.svh"
// How it works
// - write strobe goes low together with the data strobe on writes
// - write strobe floats in cycles not granted to this processor
// - high ready adds whole clock wait states
// - an external cycle ends once ready is seen low or on a timeout
// - internal cycles ignore ready and never wait
// - ready high over two timeout clock falls with strobe low is a timeout
// - timeout sets the bus timeout bit of the fault register
// - timeout abandons the cycle and returns to idle to wait for the next start
// - unmasked timeout requests level 1 interrupt after the instruction
// - timeout disable input suppresses every timeout fault
// - read strobe low with data strobe, high on the capture edge
// - direction high for reads, low for writes, held all cycle
module bus_strobe_wait
	import bus_strobe_pkg::*;
#(
	parameter int EDGES = `TIMEOUT_EDGES
) (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic start_in,
	input wire logic write_in,
	input wire logic internal_in,
	input wire logic granted_in,
	input wire logic instr_end_in,
	input wire logic mask_in,
	input wire logic fault_clear_in,
	input wire logic ready_low_in,
	input wire logic timeout_clock_in,
	input wire logic timeout_disable_n_in,
	output logic busy_out,
	output logic done_out,
	output logic capture_out,
	output logic data_strobe_n_out,
	output logic read_strobe_n_out,
	output logic write_strobe_n_out,
	output logic strobe_oe_out,
	output logic direction_select_out,
	output logic [`FAULT_WIDTH-1:0] fault_out,
	output logic irq_req_out,
	output logic [3:0] irq_level_out
);
	cycle_state_t state_q;
	logic write_q;
	logic ds_n_q;
	logic rd_n_q;
	logic wr_n_q;
	logic oe_q;
	logic dir_q;
	logic pend_q;
	logic irq_q;
	logic done_q;
	logic [`FAULT_WIDTH-1:0] fault_q;
	logic waiting;
	logic timeout;
	logic finish;
	// ----------------------------------------
	// timeout detection
	// ----------------------------------------
	// ready seen low ends the cycle normally, so it also clears the count
	assign waiting = (state_q == ST_STROBE) && !ds_n_q && ready_low_in;
	timeout_detect #(.EDGES(EDGES)) timeout_detect_i (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.timeout_clock_in(timeout_clock_in),
		.waiting_in(waiting),
		.timeout_disable_n_in(timeout_disable_n_in),
		.timeout_out(timeout)
	);
	// ready is looked at only in the strobe phase of an external cycle
	assign finish = (state_q == ST_STROBE) && (!ready_low_in || timeout);
	// ----------------------------------------
	// state sequencer
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			state_q <= ST_IDLE;
			write_q <= 1'b0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (start_in && internal_in) begin
						state_q <= ST_INTERNAL;
					end else if (start_in && granted_in) begin
						state_q <= ST_ADDR;
						write_q <= write_in;
					end
				end
				ST_ADDR: begin
					state_q <= ST_STROBE;
				end
				ST_STROBE: begin
					if (finish) begin
						state_q <= ST_LAST;
					end else begin
						state_q <= ST_STROBE;
					end
				end
				ST_LAST: begin
					state_q <= ST_IDLE;
				end
				ST_INTERNAL: begin
					state_q <= ST_IDLE;
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end
	// ----------------------------------------
	// strobes and direction
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			ds_n_q <= 1'b1;
			rd_n_q <= 1'b1;
			wr_n_q <= 1'b1;
		end else if (state_q == ST_ADDR) begin
			ds_n_q <= 1'b0;
			rd_n_q <= write_q;
			wr_n_q <= ~write_q;
		end else if (finish) begin
			// rising write strobe lets memory latch while data still held
			ds_n_q <= 1'b1;
			rd_n_q <= 1'b1;
			wr_n_q <= 1'b1;
		end
	end
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			oe_q <= 1'b0;
			dir_q <= 1'b1;
		end else if (state_q == ST_IDLE) begin
			oe_q <= start_in && granted_in && !internal_in;
			dir_q <= !(start_in && granted_in && write_in);
		end else if (state_q == ST_LAST || state_q == ST_INTERNAL) begin
			oe_q <= 1'b0;
			dir_q <= 1'b1;
		end
	end
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			done_q <= 1'b0;
		end else begin
			done_q <= finish || (state_q == ST_INTERNAL);
		end
	end
	// ----------------------------------------
	// fault register and interrupt request
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			fault_q <= `FAULT_RESET;
		end else if (timeout) begin
			fault_q[`FAULT_BIT_TIMEOUT] <= 1'b1;
		end else if (fault_clear_in) begin
			fault_q <= `FAULT_RESET;
		end
	end
	// the request waits for the instruction boundary, never mid instruction
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			pend_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			if (timeout) begin
				pend_q <= 1'b1;
			end else if (instr_end_in) begin
				pend_q <= 1'b0;
			end
			irq_q <= (pend_q || timeout) && instr_end_in && !mask_in;
		end
	end
	assign busy_out = (state_q != ST_IDLE);
	assign done_out = done_q;
	assign capture_out = finish && !write_q;
	assign data_strobe_n_out = ds_n_q;
	assign read_strobe_n_out = rd_n_q;
	assign write_strobe_n_out = wr_n_q;
	assign strobe_oe_out = oe_q;
	assign direction_select_out = dir_q;
	assign fault_out = fault_q;
	assign irq_req_out = irq_q;
	assign irq_level_out = `LEVEL_MACHINE_ERROR;
	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_write_with_ds: assert property (@(posedge clk_in)
		disable iff (reset_in) !wr_n_q |-> !ds_n_q && write_q)
		else $error("write strobe low without data strobe");
	a_read_with_ds: assert property (@(posedge clk_in)
		disable iff (reset_in) !rd_n_q |-> !ds_n_q && !write_q)
		else $error("read strobe low without data strobe");
	a_float_idle: assert property (@(posedge clk_in)
		disable iff (reset_in)
		state_q == ST_IDLE && !oe_q |-> wr_n_q)
		else $error("write strobe active while not driven");
	a_wait_ready: assert property (@(posedge clk_in)
		disable iff (reset_in)
		state_q == ST_STROBE && ready_low_in && !timeout
		|=> state_q == ST_STROBE)
		else $error("cycle left without ready");
	a_end_ready: assert property (@(posedge clk_in)
		disable iff (reset_in)
		state_q == ST_STROBE && !ready_low_in
		|=> state_q == ST_LAST ##1 state_q == ST_IDLE)
		else $error("cycle not ended after ready");
	a_internal_fast: assert property (@(posedge clk_in)
		disable iff (reset_in)
		state_q == ST_INTERNAL |=> state_q == ST_IDLE && ds_n_q)
		else $error("internal cycle waited");
	a_timeout_fault: assert property (@(posedge clk_in)
		disable iff (reset_in)
		timeout |=> fault_q[`FAULT_BIT_TIMEOUT] && state_q == ST_LAST)
		else $error("timeout not recorded or cycle not ended");
	a_irq_cause: assert property (@(posedge clk_in)
		disable iff (reset_in)
		irq_q |-> $past(instr_end_in) && !$past(mask_in))
		else $error("interrupt without boundary or while masked");
	a_dir_hold: assert property (@(posedge clk_in)
		disable iff (reset_in)
		state_q == ST_STROBE |-> dir_q == !write_q)
		else $error("direction wrong during cycle");
	a_no_timeout_off: assert property (@(posedge clk_in)
		disable iff (reset_in)
		!timeout_disable_n_in |=> !$rose(fault_q[`FAULT_BIT_TIMEOUT]))
		else $error("timeout fault set while disabled");
	// ----------------------------------------
	// checks on the cycle sequence
	// ----------------------------------------
	a_strobe_low: assert property (@(posedge clk_in)
		disable iff (reset_in) state_q == ST_STROBE |-> !ds_n_q)
		else $error("data strobe high in strobe phase");
	a_idle_high: assert property (@(posedge clk_in)
		disable iff (reset_in)
		state_q == ST_IDLE |-> ds_n_q && rd_n_q && wr_n_q)
		else $error("strobe low while idle");
	a_drive_cycle: assert property (@(posedge clk_in)
		disable iff (reset_in)
		state_q inside {ST_ADDR, ST_STROBE, ST_LAST} |-> oe_q)
		else $error("strobes not driven in own cycle");
	a_float_internal: assert property (@(posedge clk_in)
		disable iff (reset_in)
		state_q == ST_INTERNAL |-> !oe_q && ds_n_q)
		else $error("strobes driven in internal cycle");
	a_refuse_ungranted: assert property (@(posedge clk_in)
		disable iff (reset_in)
		state_q == ST_IDLE && start_in && !granted_in && !internal_in
		|=> state_q == ST_IDLE && !oe_q)
		else $error("external cycle started without grant");
	a_take_internal: assert property (@(posedge clk_in)
		disable iff (reset_in)
		state_q == ST_IDLE && start_in && internal_in
		|=> state_q == ST_INTERNAL)
		else $error("internal cycle not taken");
	a_take_external: assert property (@(posedge clk_in)
		disable iff (reset_in)
		state_q == ST_IDLE && start_in && granted_in && !internal_in
		|=> state_q == ST_ADDR && oe_q && dir_q == !write_q)
		else $error("external cycle not taken");
	a_addr_to_strobe: assert property (@(posedge clk_in)
		disable iff (reset_in)
		state_q == ST_ADDR |=> state_q == ST_STROBE && !ds_n_q)
		else $error("strobe phase not entered");
	a_dir_stable: assert property (@(posedge clk_in)
		disable iff (reset_in)
		state_q inside {ST_STROBE, ST_LAST}
		|-> $stable(dir_q) && $stable(write_q))
		else $error("direction moved within cycle");
	a_write_dir: assert property (@(posedge clk_in)
		disable iff (reset_in) !wr_n_q |-> !dir_q && oe_q)
		else $error("write strobe without write direction");
	a_read_dir: assert property (@(posedge clk_in)
		disable iff (reset_in) !rd_n_q |-> dir_q && oe_q)
		else $error("read strobe without read direction");
	a_capture_edge: assert property (@(posedge clk_in)
		disable iff (reset_in) capture_out |=> rd_n_q && ds_n_q)
		else $error("read strobe not raised on capture");
	a_capture_read: assert property (@(posedge clk_in)
		disable iff (reset_in) capture_out |-> !rd_n_q)
		else $error("capture outside a read strobe");
	a_write_rise: assert property (@(posedge clk_in)
		disable iff (reset_in) !wr_n_q && finish |=> wr_n_q)
		else $error("write strobe not raised at cycle end");
	a_last_to_idle: assert property (@(posedge clk_in)
		disable iff (reset_in)
		state_q == ST_LAST |=> state_q == ST_IDLE && !oe_q)
		else $error("strobes still driven after cycle");
	a_dir_release: assert property (@(posedge clk_in)
		disable iff (reset_in) state_q == ST_LAST |=> dir_q && ds_n_q)
		else $error("direction not back to read after cycle");
	a_done_after: assert property (@(posedge clk_in)
		disable iff (reset_in) finish |=> done_q)
		else $error("cycle end not reported");
	a_done_pulse: assert property (@(posedge clk_in)
		disable iff (reset_in) done_q |=> !done_q)
		else $error("done longer than one cycle");
	// ----------------------------------------
	// checks on faults and the request
	// ----------------------------------------
	a_timeout_in_strobe: assert property (@(posedge clk_in)
		disable iff (reset_in)
		timeout |-> state_q == ST_STROBE && !ds_n_q && ready_low_in)
		else $error("timeout outside a waiting strobe");
	a_fault_cause: assert property (@(posedge clk_in)
		disable iff (reset_in)
		$rose(fault_q[`FAULT_BIT_TIMEOUT]) |-> $past(timeout))
		else $error("timeout bit set without timeout");
	a_fault_clear: assert property (@(posedge clk_in)
		disable iff (reset_in)
		fault_clear_in && !timeout |=> fault_q == `FAULT_RESET)
		else $error("fault register not cleared");
	a_irq_unmasked: assert property (@(posedge clk_in)
		disable iff (reset_in)
		timeout && instr_end_in && !mask_in |=> irq_q)
		else $error("request missing at boundary");
	a_irq_pending: assert property (@(posedge clk_in)
		disable iff (reset_in)
		pend_q && instr_end_in && !mask_in |=> irq_q)
		else $error("pending request not raised");
	a_irq_masked: assert property (@(posedge clk_in)
		disable iff (reset_in) mask_in |=> !irq_q)
		else $error("request raised while masked");
	a_pend_clear: assert property (@(posedge clk_in)
		disable iff (reset_in) instr_end_in && !timeout |=> !pend_q)
		else $error("pending request kept past boundary");
endmodule : bus_strobe_wait
`default_nettype wire

//--- tb/ext_device.sv
// far side memory model: answers the strobes with ready after some waits
`timescale 1ns/1ns
`default_nettype none
module ext_device (
	input wire logic clk_in,
	input wire logic data_strobe_n_in,
	input wire logic write_strobe_n_in,
	input wire logic [7:0] waits_in,
	output logic ready_low_out,
	output var logic [7:0] writes_out
);
	logic [7:0] cnt_q = 8'h00;
	initial writes_out = 8'h00;
	// ready moves on the falling clock, away from the sampling edge
	always @(negedge clk_in) begin
		if (data_strobe_n_in)
			cnt_q <= 8'h00;
		else if (cnt_q != 8'hFF)
			cnt_q <= cnt_q + 8'h01;
	end
	// 8'hFF means never ready, which provokes a bus timeout
	assign ready_low_out = (waits_in == 8'hFF) || (cnt_q <= waits_in);
	always @(posedge write_strobe_n_in) writes_out <= writes_out + 8'h01;
endmodule : ext_device
`default_nettype wire

//--- tb/bus_strobe_wait_tb.sv
// self-checking testbench for the bus strobe and wait state block
`timescale 1ns/1ns
`default_nettype none
`include "bus_strobe_cfg.svh"
module bus_strobe_wait_tb;
	logic clk = 1'b0, rst = 1'b1, start = 1'b0, wr = 1'b0, intl = 1'b0;
	logic grant = 1'b1, iend = 1'b0, mask = 1'b0, fclr = 1'b0;
	logic timeout_clock = 1'b1, tdis_n = 1'b1, rdy_n;
	logic busy, done, cap, ds_n, rd_n, wr_n, oe, dir, irq;
	logic [15:0] fault;
	logic [3:0] lvl;
	logic [7:0] waits = 8'h00, writes;
	int failures = 0, total_checks = 0;
	int caps = 0;
	always #5 clk = ~clk;
	// timeout clock is eight processor clocks per period
	always #40 timeout_clock = ~timeout_clock;
	// capture is combinational: count it with the values the edge samples
	always @(posedge clk) begin
		if (cap === 1'b1) caps++;
	end
	bus_strobe_wait bus_strobe_wait_i (.clk_in(clk), .reset_in(rst),
		.start_in(start), .write_in(wr), .internal_in(intl),
		.granted_in(grant), .instr_end_in(iend), .mask_in(mask),
		.fault_clear_in(fclr), .ready_low_in(rdy_n),
		.timeout_clock_in(timeout_clock), .timeout_disable_n_in(tdis_n),
		.busy_out(busy), .done_out(done), .capture_out(cap),
		.data_strobe_n_out(ds_n), .read_strobe_n_out(rd_n),
		.write_strobe_n_out(wr_n), .strobe_oe_out(oe),
		.direction_select_out(dir), .fault_out(fault),
		.irq_req_out(irq), .irq_level_out(lvl));
	ext_device ext_device_i (.clk_in(clk), .data_strobe_n_in(ds_n),
		.write_strobe_n_in(wr_n), .waits_in(waits),
		.ready_low_out(rdy_n), .writes_out(writes));
	task automatic chk(input string name, input logic [15:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic summarize;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : summarize
	// one cycle; dsx below zero skips the strobe length check
	task automatic run(input logic w, i, input logic [7:0] n, input int dsx);
		int k;
		int dsc;
		logic [7:0] w0;
		int c0;
		w0 = writes;
		c0 = caps;
		dsc = 0;
		waits = n;
		wr = w;
		intl = i;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		for (k = 0; k < 60 && done !== 1'b1; k++) begin
			chk("busy", busy, 1'b1);
			if (ds_n === 1'b0) begin
				dsc++;
				chk("read strobe", rd_n, w);
				chk("write strobe", wr_n, !w);
			end
			if (oe === 1'b1 && !i) chk("direction", dir, !w);
			@(negedge clk);
		end
		chk("done", done, 1'b1);
		if (dsx >= 0) chk("strobe cycles", 16'(dsc), 16'(dsx));
		chk("captures", 16'(caps - c0), 16'(!w && !i));
		if (w) chk("writes latched", writes, w0 + 8'h01);
		@(negedge clk);
	endtask : run
	task automatic timeout_case(input logic m);
		logic seen;
		mask = m;
		run(1'b0, 1'b0, 8'hFF, -1);
		chk("timeout fault", fault, 16'h0001 << `FAULT_BIT_TIMEOUT);
		chk("early request", irq, 1'b0);
		iend = 1'b1;
		@(negedge clk);
		iend = 1'b0;
		seen = irq;
		@(negedge clk);
		seen = seen | irq;
		chk("level 1 request", seen, !m);
		chk("request level", lvl, `LEVEL_MACHINE_ERROR);
		fclr = 1'b1;
		@(negedge clk);
		fclr = 1'b0;
		@(negedge clk);
		chk("fault cleared", fault, 16'h0000);
	endtask : timeout_case
	initial begin
		repeat (8) @(negedge clk);
		rst = 1'b0;
		chk("idle enable", oe, 1'b0);
		run(1'b0, 1'b0, 8'h00, 1);
		run(1'b1, 1'b0, 8'h02, 3);
		grant = 1'b0;
		// ready never comes, yet an internal cycle must finish
		run(1'b0, 1'b1, 8'hFF, 0);
		intl = 1'b0;
		start = 1'b1;
		repeat (4) @(negedge clk);
		start = 1'b0;
		chk("busy without grant", busy, 1'b0);
		chk("enable without grant", oe, 1'b0);
		grant = 1'b1;
		timeout_case(1'b0);
		timeout_case(1'b1);
		mask = 1'b0;
		tdis_n = 1'b0;
		// thirty waits span several timeout clock falls
		run(1'b1, 1'b0, 8'h1E, 31);
		chk("disabled fault", fault, 16'h0000);
		summarize();
	end
	initial begin
		#100000;
		failures++;
		summarize();
	end
endmodule : bus_strobe_wait_tb
`default_nettype wire
